/* File: verilog/iqa_pkg.sv */
package iqa_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned DATA_W   = 18;
  localparam int unsigned GPIO_W   = 16;
  localparam int unsigned IRQ_W    = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_FIRST_CTRL  = 8'h00;
  localparam logic [7:0] OFS_SECOND_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h10;
  localparam logic [7:0] OFS_I_WORD      = 8'h14;
  localparam logic [7:0] OFS_Q_WORD      = 8'h18;
  localparam logic [7:0] OFS_GPIO_IN     = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] RST_FIRST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_SECOND_CTRL = 32'h0000_0820;
  localparam logic [31:0] RST_IRQ_MASK    = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned FLD_MODE_LO     = 24;
  localparam int unsigned FLD_SERIAL_SEL  = 31;
  localparam int unsigned FLD_HALF_RATE   = 13;
  localparam int unsigned FLD_OFFSET_BIN  = 12;
  localparam int unsigned FLD_CLK_OE      = 11;
  localparam int unsigned FLD_CLK_INV     = 10;
  localparam int unsigned FLD_GATE_INV    = 9;
  localparam int unsigned FLD_Q_FIRST     = 8;
  localparam int unsigned FLD_HOLD_LAST   = 6;
  localparam int unsigned FLD_SYNC_DIS    = 5;
  localparam int unsigned SERIAL_LO_PIN   = 4;
  localparam logic [1:0]  MODE_QDUC       = 2'h0;
  localparam logic [1:0]  MODE_TONE       = 2'h1;
  localparam int unsigned IRQ_PAIR        = 0;
  localparam int unsigned IRQ_SYNC        = 1;
  localparam int unsigned IRQ_GATE        = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // timing: word period in pclk cycles
  localparam int unsigned PCLK_MHZ        = 40;
  localparam int unsigned WORD_NS         = 50;
  localparam int unsigned WORD_CYC        = (WORD_NS * PCLK_MHZ) / 1000;

  typedef struct packed {
    logic [DATA_W-1:0] i_word;
    logic [DATA_W-1:0] q_word;
  } iqa_pair_t;

endpackage

/* File: verilog/iqa_assembler.sv */
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RQ1: rate select acts only in parallel port mode with operating mode 00b
// RQ2: rate bit 0 runs word clock at word rate, 1 at half rate
// RQ3: format bit 0 means twos complement words, 1 means offset binary
// RQ4: clock enable 0 holds clock pin low; internal clock keeps timing
// RQ5: clock enable 1 drives internal word clock onto the pin
// RQ6: normal polarity puts Q on clock high, I on low; invert reverses
// RQ7: gate invert 0: high transmits; invert 1: low transmits
// RQ8: pairing bit 0 sends I first, 1 sends Q first
// RQ9: hold-last selection ignored in single tone mode
// RQ10: hold 0: gate inactive ignores pins and outputs zeros
// RQ11: hold 1: gate inactive ignores pins and keeps last sample
// RQ12: validation enabled reports possible setup/hold violation on fault output
// RQ13: fault result latched until validation disable bit set
// RQ14: disable bit 1 resets checker and holds fault output low
// RQ15: serial select makes two pins dual serial input, rest 16-bit GPIO
// RQ16: source presents one word per clock phase, ordered and coded as set
module iqa_assembler #(
  parameter int unsigned WORD_DIV = iqa_pkg::WORD_CYC
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [iqa_pkg::DATA_W-1:0] data_pins,
  input  wire logic                      transmit_gate,
  input  wire logic                      sync_timing_miss,
  output logic                           parallel_word_clock,
  output logic                           sync_sample_fault,
  output iqa_pkg::iqa_pair_t             baseband,
  output logic                           baseband_valid,
  output logic [1:0]                     dual_serial_input,
  output logic                           irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // registers and wires
  logic [31:0]                 first_control_config_r;
  logic [31:0]                 second_control_config_r;
  logic [iqa_pkg::IRQ_W-1:0]   irq_status_r;
  logic [iqa_pkg::IRQ_W-1:0]   irq_mask_r;
  logic [iqa_pkg::IRQ_W-1:0]   irq_event;
  logic [iqa_pkg::DATA_W-1:0]  data_s1_r;
  logic [iqa_pkg::DATA_W-1:0]  data_s2_r;
  logic [2:0]                  ctl_s1_r;
  logic [2:0]                  ctl_s2_r;
  logic [15:0]                 div_cnt_r;
  logic                        word_tick;
  logic                        word_sel_r;
  logic [2:0]                  tick_dly_r;
  logic [2:0]                  sel_dly_r;
  logic                        pair_phase_r;
  logic [iqa_pkg::DATA_W-1:0]  first_word_r;
  logic [iqa_pkg::DATA_W-1:0]  word_coded;
  logic [iqa_pkg::DATA_W-1:0]  i_new;
  logic [iqa_pkg::DATA_W-1:0]  q_new;
  logic                        gate_active;
  logic                        gate_prev_r;
  logic                        sync_latch_r;
  logic                        clk_int;
  logic                        clk_pin_nxt;
  logic                        serial_mode;
  logic                        half_rate;
  logic                        hold_last;
  logic                        wr_en;
  logic                        rd_en;
  logic                        addr_ok;
  logic [31:0]                 rd_nxt;
  logic [1:0]                  op_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration decode
  assign op_mode     = first_control_config_r[iqa_pkg::FLD_MODE_LO +: 2];
  assign serial_mode = second_control_config_r[iqa_pkg::FLD_SERIAL_SEL];
  // rate bit honoured only in parallel mode with quadrature operating mode [RQ1]
  assign half_rate   = second_control_config_r[iqa_pkg::FLD_HALF_RATE] & ~serial_mode
                       & (op_mode == iqa_pkg::MODE_QDUC);
  // hold selection forced off in single tone mode [RQ9]
  assign hold_last   = second_control_config_r[iqa_pkg::FLD_HOLD_LAST]
                       & (op_mode != iqa_pkg::MODE_TONE);
  // gate polarity [RQ7]
  assign gate_active = ctl_s2_r[0] ^ second_control_config_r[iqa_pkg::FLD_GATE_INV];

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_s1_r <= '0;
      data_s2_r <= '0;
      ctl_s1_r  <= '0;
      ctl_s2_r  <= '0;
    end
    else
    begin
      data_s1_r <= data_pins;
      data_s2_r <= data_s1_r;
      ctl_s1_r  <= {sync_timing_miss, 1'b0, transmit_gate};
      ctl_s2_r  <= ctl_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // word rate divider and internal word clock
  assign word_tick = (div_cnt_r == 16'(WORD_DIV - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_r    <= '0;
      word_sel_r   <= 1'b0;
      pair_phase_r <= 1'b0;
    end
    else if (word_tick)
    begin
      div_cnt_r  <= '0;
      word_sel_r <= ~word_sel_r;
      if (word_sel_r)
      begin
        pair_phase_r <= ~pair_phase_r;
      end
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  // tick and word phase delayed past the pin register and both synchroniser stages [RQ6]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_dly_r <= '0;
      sel_dly_r  <= '0;
    end
    else
    begin
      tick_dly_r <= {tick_dly_r[1:0], word_tick};
      sel_dly_r  <= {sel_dly_r[1:0], word_sel_r};
    end
  end

  // full rate: one clock phase per word; half rate: one phase per pair [RQ2]
  // at full rate the first word sits in the phase that matches its I or Q association [RQ6] [RQ8]
  always_comb
  begin
    if (half_rate)
    begin
      clk_int = pair_phase_r;
    end
    else
    begin
      clk_int = word_sel_r ^ second_control_config_r[iqa_pkg::FLD_Q_FIRST];
    end
    // pin inversion and static low when disabled [RQ4] [RQ5] [RQ6]
    clk_pin_nxt = second_control_config_r[iqa_pkg::FLD_CLK_OE]
                  & (clk_int ^ second_control_config_r[iqa_pkg::FLD_CLK_INV]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      parallel_word_clock <= 1'b0;
    end
    else
    begin
      parallel_word_clock <= clk_pin_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data assembler
  // offset binary converted to twos complement by flipping the sign bit [RQ3]
  assign word_coded = {data_s2_r[iqa_pkg::DATA_W-1]
                       ^ second_control_config_r[iqa_pkg::FLD_OFFSET_BIN],
                       data_s2_r[iqa_pkg::DATA_W-2:0]};
  // pairing order picks which word is I [RQ8] [RQ16]
  assign i_new = second_control_config_r[iqa_pkg::FLD_Q_FIRST] ? word_coded : first_word_r;
  assign q_new = second_control_config_r[iqa_pkg::FLD_Q_FIRST] ? first_word_r : word_coded;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_word_r   <= '0;
      baseband       <= '0;
      baseband_valid <= 1'b0;
    end
    else
    begin
      baseband_valid <= 1'b0;
      if (tick_dly_r[2] && !serial_mode)
      begin
        if (gate_active)
        begin
          if (!sel_dly_r[2])
          begin
            first_word_r <= word_coded;
          end
          else
          begin
            baseband.i_word <= i_new;
            baseband.q_word <= q_new;
            baseband_valid  <= 1'b1;
          end
        end
        else if (sel_dly_r[2])
        begin
          // pins ignored while gate inactive [RQ10] [RQ11]
          if (!hold_last)
          begin
            baseband <= '0;  // [RQ10]
          end
          baseband_valid <= 1'b1;  // [RQ11]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // dual serial input pins in serial port mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dual_serial_input <= '0;
    end
    else if (serial_mode)
    begin
      dual_serial_input <= data_s2_r[iqa_pkg::SERIAL_LO_PIN +: 2];  // [RQ15]
    end
    else
    begin
      dual_serial_input <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sync setup/hold checker
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_latch_r      <= 1'b0;
      sync_sample_fault <= 1'b0;
    end
    else if (second_control_config_r[iqa_pkg::FLD_SYNC_DIS])
    begin
      sync_latch_r      <= 1'b0;  // [RQ14]
      sync_sample_fault <= 1'b0;  // [RQ14]
    end
    else
    begin
      // latched until disabled [RQ12] [RQ13]
      sync_latch_r      <= sync_latch_r | ctl_s2_r[2];
      sync_sample_fault <= sync_latch_r | ctl_s2_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_prev_r <= 1'b0;
    end
    else
    begin
      gate_prev_r <= gate_active;
    end
  end

  assign irq_event[iqa_pkg::IRQ_PAIR] = baseband_valid;
  assign irq_event[iqa_pkg::IRQ_SYNC] = ~sync_latch_r & ctl_s2_r[2]
                                        & ~second_control_config_r[iqa_pkg::FLD_SYNC_DIS];
  assign irq_event[iqa_pkg::IRQ_GATE] = gate_active ^ gate_prev_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      // set wins over write-one-to-clear
      if (wr_en && paddr == iqa_pkg::OFS_IRQ_STATUS)
      begin
        irq_status_r <= (irq_status_r & ~pwdata[iqa_pkg::IRQ_W-1:0]) | irq_event;
      end
      else
      begin
        irq_status_r <= irq_status_r | irq_event;
      end
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, then registered answer
  assign wr_en = psel & penable & pready & pwrite & addr_ok;
  assign rd_en = psel & penable & ~pready;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_nxt  = 32'h0000_0000;
    if (paddr == iqa_pkg::OFS_FIRST_CTRL)
    begin
      rd_nxt = first_control_config_r;
    end
    else if (paddr == iqa_pkg::OFS_SECOND_CTRL)
    begin
      rd_nxt = second_control_config_r;
    end
    else if (paddr == iqa_pkg::OFS_STATUS)
    begin
      rd_nxt = {29'h0, gate_active, sync_sample_fault, parallel_word_clock};
    end
    else if (paddr == iqa_pkg::OFS_IRQ_STATUS)
    begin
      rd_nxt = {29'h0, irq_status_r};
    end
    else if (paddr == iqa_pkg::OFS_IRQ_MASK)
    begin
      rd_nxt = {29'h0, irq_mask_r};
    end
    else if (paddr == iqa_pkg::OFS_I_WORD)
    begin
      rd_nxt = {14'h0, baseband.i_word};
    end
    else if (paddr == iqa_pkg::OFS_Q_WORD)
    begin
      rd_nxt = {14'h0, baseband.q_word};
    end
    else if (paddr == iqa_pkg::OFS_GPIO_IN)
    begin
      // general purpose inputs only in serial port mode [RQ15]
      rd_nxt = serial_mode ? {16'h0, data_s2_r[17:6], data_s2_r[3:0]} : 32'h0000_0000;
    end
    else
    begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= rd_en;
      pslverr <= rd_en & ~addr_ok;
      if (rd_en && !pwrite)
      begin
        prdata <= rd_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_control_config_r  <= iqa_pkg::RST_FIRST_CTRL;
      second_control_config_r <= iqa_pkg::RST_SECOND_CTRL;
      irq_mask_r              <= iqa_pkg::RST_IRQ_MASK[iqa_pkg::IRQ_W-1:0];
    end
    else if (wr_en)
    begin
      if (paddr == iqa_pkg::OFS_FIRST_CTRL)
      begin
        first_control_config_r <= pwdata;
      end
      else if (paddr == iqa_pkg::OFS_SECOND_CTRL)
      begin
        second_control_config_r <= pwdata;
      end
      else if (paddr == iqa_pkg::OFS_IRQ_MASK)
      begin
        irq_mask_r <= pwdata[iqa_pkg::IRQ_W-1:0];
      end
    end
  end

endmodule

`default_nettype wire

/* File: sim/iqa_assembler_props.sv */
`timescale 1ns/10ps
`default_nettype none
module iqa_assembler_props #(
  parameter int unsigned WORD_DIV = 2
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic [iqa_pkg::DATA_W-1:0] data_pins,
  input wire logic                       transmit_gate,
  input wire logic                       sync_timing_miss,
  input wire logic                       parallel_word_clock,
  input wire logic                       sync_sample_fault,
  input wire iqa_pkg::iqa_pair_t         baseband,
  input wire logic                       baseband_valid,
  input wire logic [1:0]                 dual_serial_input,
  input wire logic                       irq
);
  localparam int WD = WORD_DIV;
  logic [31:0] s1_r;
  logic [31:0] s2_r;
  logic        tone;
  logic        hr;
  logic        idle;
  assign tone = s1_r[25:24] == iqa_pkg::MODE_TONE;
  assign hr   = s2_r[13] && !s2_r[31] && s1_r[25:24] == iqa_pkg::MODE_QDUC;
  assign idle = transmit_gate == s2_r[9];
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of control writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= iqa_pkg::RST_FIRST_CTRL;
      s2_r <= iqa_pkg::RST_SECOND_CTRL;
    end
    else if (psel && penable && pready && pwrite && !pslverr)
    begin
      if (paddr == iqa_pkg::OFS_FIRST_CTRL) s1_r <= pwdata;
      if (paddr == iqa_pkg::OFS_SECOND_CTRL) s2_r <= pwdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_miss_seen;
    (sync_timing_miss && !s2_r[5])[*4];
  endsequence
  sequence s_idle_slot;
    idle && $past(idle, 4) && $past(idle, 8) && baseband_valid &&
    $past(s2_r, 4) == s2_r && $past(s1_r, 4) == s1_r;
  endsequence
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_fault_report: assert property (s_miss_seen |-> ##[0:3] sync_sample_fault)
    else $error("sync fault not raised");
  a_fault_held: assert property (!s2_r[5] && $past(sync_sample_fault) |-> sync_sample_fault)
    else $error("sync fault dropped while enabled");
  a_fault_forced: assert property (s2_r[5] && $past(s2_r[5]) |-> !sync_sample_fault)
    else $error("sync fault high while disabled");
  a_clk_low: assert property (!s2_r[11] && !$past(s2_r[11]) |-> !parallel_word_clock)
    else $error("word clock pin not low");
  a_full_rate: assert property ($changed(parallel_word_clock) ##WD (s2_r[11] && !hr
    && $past(s2_r, 4) == s2_r && $past(s1_r, 4) == s1_r) |-> $changed(parallel_word_clock))
    else $error("word clock not at word rate");
  a_half_rate: assert property (hr && s2_r[11] && $past(s2_r, 4) == s2_r
    && $past(s1_r, 4) == s1_r && $changed(parallel_word_clock)
    |=> ($stable(parallel_word_clock) || !hr)[*3])
    else $error("word clock not at half rate");
  a_idle_zero: assert property (s_idle_slot |-> (s2_r[6] && !tone) || baseband == '0)
    else $error("idle baseband not zero");
  a_idle_hold: assert property (s_idle_slot |-> !s2_r[6] || tone || $stable(baseband))
    else $error("idle baseband not held");
endmodule
bind iqa_assembler iqa_assembler_props #(.WORD_DIV(WORD_DIV)) iqa_assembler_props_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .data_pins, .transmit_gate, .sync_timing_miss, .parallel_word_clock, .sync_sample_fault,
  .baseband, .baseband_valid, .dual_serial_input, .irq
);
`default_nettype wire

/* File: sim/iqa_source_model.sv */
`timescale 1ns/10ps
`default_nettype none
module iqa_source_model (
  input  wire logic                       parallel_word_clock,
  input  wire logic                       active,
  input  wire logic                       clk_inv,
  input  wire logic                       gate_inv,
  input  wire logic                       offset_bin,
  input  wire logic [iqa_pkg::DATA_W-1:0] i_val,
  input  wire logic [iqa_pkg::DATA_W-1:0] q_val,
  output logic      [iqa_pkg::DATA_W-1:0] data_pins,
  output logic                            transmit_gate
);
  logic [iqa_pkg::DATA_W-1:0] fmt;
  assign fmt = offset_bin ? {1'b1, {(iqa_pkg::DATA_W-1){1'b0}}} : '0;
  assign transmit_gate = active ^ gate_inv;
  initial data_pins = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // one word per clock phase; pins churn in standby
  always @(parallel_word_clock or active)
  begin
    if (!active)
      data_pins = ~data_pins;
    else if (parallel_word_clock ^ clk_inv)
      data_pins = q_val ^ fmt;
    else
      data_pins = i_val ^ fmt;
  end
endmodule
`default_nettype wire

/* File: sim/iqa_assembler_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module iqa_assembler_tb;
  localparam int          WD  = 2;
  localparam logic [31:0] RST = iqa_pkg::RST_SECOND_CTRL;
  logic                       pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                       pwrite = 1'b0, sync_timing_miss = 1'b0, active = 1'b0;
  logic                       clk_inv = 1'b0, gate_inv = 1'b0, offset_bin = 1'b0;
  logic                       pready, pslverr, er, transmit_gate, parallel_word_clock;
  logic                       sync_sample_fault, baseband_valid, irq;
  logic [7:0]                 paddr = 8'h00;
  logic [31:0]                pwdata = 32'h0, prdata, rd;
  logic [1:0]                 dual_serial_input;
  logic [iqa_pkg::DATA_W-1:0] data_pins, i_val = '0, q_val = '0;
  iqa_pkg::iqa_pair_t         baseband;
  int                         num_errors = 0, checked = 0, cyc = 0, c;
  iqa_assembler #(.WORD_DIV(WD)) iqa_assembler_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .data_pins, .transmit_gate, .sync_timing_miss, .parallel_word_clock, .sync_sample_fault,
    .baseband, .baseband_valid, .dual_serial_input, .irq
  );
  iqa_source_model iqa_source_model_inst (
    .parallel_word_clock, .active, .clk_inv, .gate_inv, .offset_bin, .i_val, .q_val,
    .data_pins, .transmit_gate
  );
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      num_errors++;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cfg(input logic [31:0] v);
    clk_inv    <= v[iqa_pkg::FLD_CLK_INV];
    gate_inv   <= v[iqa_pkg::FLD_GATE_INV];
    offset_bin <= v[iqa_pkg::FLD_OFFSET_BIN];
    apb(1'b1, iqa_pkg::OFS_SECOND_CTRL, v);
  endtask
  task automatic wait_pair(input int n);
    repeat (n)
      do @(posedge pclk); while (baseband_valid !== 1'b1);
  endtask
  task automatic cnt;
    logic l;
    c = 0;
    repeat (4) @(posedge pclk);
    l = parallel_word_clock;
    repeat (32)
    begin
      @(posedge pclk);
      if (parallel_word_clock !== l) c++;
      l = parallel_word_clock;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_stream;
    logic [31:0] v;
    active <= 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      v = RST | (32'(k & 8) << 9) | (32'(k & 7) << 8);
      i_val <= 18'h2_0000 + 18'(k);
      q_val <= 18'h1_FFF0 - 18'(k);
      cfg(v);
      wait_pair(4);
      chk(baseband, {18'h2_0000 + 18'(k), 18'h1_FFF0 - 18'(k)});
    end
  endtask
  task automatic t_idle;
    i_val <= 18'h0_1234;
    q_val <= 18'h3_4321;
    cfg(RST);
    wait_pair(4);
    active <= 1'b0;
    wait_pair(4);
    chk(baseband, 36'h0);
    active <= 1'b1;
    cfg(RST | 32'h40);
    wait_pair(4);
    active <= 1'b0;
    wait_pair(4);
    chk(baseband, {18'h0_1234, 18'h3_4321});
    apb(1'b1, iqa_pkg::OFS_FIRST_CTRL, 32'h0100_0000);
    wait_pair(4);
    chk(baseband, 36'h0);
    apb(1'b1, iqa_pkg::OFS_FIRST_CTRL, 32'h0);
  endtask
  task automatic t_clock;
    logic [17:0] w;
    cfg(RST & ~32'h800);
    cnt();
    chk(36'(c), 36'h0);
    wait_pair(2);
    cfg(RST);
    cnt();
    chk(36'(c), 36'(32 / WD));
    cfg(RST | 32'h2000);
    cnt();
    chk(36'(c), 36'(32 / (2 * WD)));
    apb(1'b1, iqa_pkg::OFS_FIRST_CTRL, 32'h0100_0000);
    cnt();
    chk(36'(c), 36'(32 / WD));
    apb(1'b1, iqa_pkg::OFS_FIRST_CTRL, 32'h0);
    w = 18'h2_AAE5;
    i_val <= w;
    q_val <= w;
    active <= 1'b1;
    cfg(RST | 32'h8000_2000);
    cnt();
    chk(36'(c), 36'(32 / WD));
    chk(dual_serial_input, w[5:4]);
    apb(1'b0, iqa_pkg::OFS_GPIO_IN, 32'h0);
    chk(rd, {w[17:6], w[3:0]});
    cfg(RST);
    cnt();
    chk(dual_serial_input, 2'h0);
  endtask
  task automatic t_sync;
    cfg(RST & ~32'h20);
    repeat (6) @(posedge pclk);
    chk(sync_sample_fault, 1'b0);
    sync_timing_miss <= 1'b1;
    repeat (6) @(posedge pclk);
    sync_timing_miss <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(sync_sample_fault, 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, iqa_pkg::OFS_IRQ_MASK, 32'h1 << iqa_pkg::IRQ_SYNC);
    @(posedge pclk);
    chk(irq, 1'b1);
    cfg(RST);
    sync_timing_miss <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(sync_sample_fault, 1'b0);
    sync_timing_miss <= 1'b0;
    apb(1'b1, iqa_pkg::OFS_IRQ_STATUS, 32'h1 << iqa_pkg::IRQ_SYNC);
    @(posedge pclk);
    chk(irq, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, iqa_pkg::OFS_SECOND_CTRL, 32'h0);
    chk(rd, RST);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    t_stream();
    t_idle();
    t_clock();
    t_sync();
    end_sim();
  end
endmodule
`default_nettype wire
